// ===== hdl/dmc_regs.sv
// Configuration register bank of the quadrature demodulator, loaded
// over the three-wire serial port, plus the calibration clock divider.
// Assumes serial pins, oscillator tick are asynchronous; cal_done is
// driven by calibration logic on ref_clk.
`timescale 1ns/1ps
module dmc_regs (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic ser_clk,
   input wire logic ser_data,
   input wire logic ser_latch,
   input wire logic osc_tick,
   input wire logic cal_done,
   output logic autocal_en,
   output logic [7:0] i_offset_dac_value,
   output logic [7:0] q_offset_dac_value,
   output logic [1:0] cal_ref_current_sel,
   output logic cal_mode_auto,
   output logic [2:0] cal_clk_div_sel,
   output logic cal_clk_src_osc,
   output logic [2:0] osc_trim,
   output logic cal_clk_tick,
   output logic [5:0] i_mixer_load_side_a,
   output logic [5:0] i_mixer_load_side_b,
   output logic [5:0] q_mixer_load_side_a,
   output logic [5:0] q_mixer_load_side_b,
   output logic filter_bypass,
   output logic [1:0] filter_peak_ctrl,
   output logic [1:0] mixer_transcond_trim,
   output logic [1:0] mixer_switch_vcm_trim,
   output logic [1:0] lo_buffer_trim,
   output logic [1:0] mixer_outbuf_trim,
   output logic [1:0] filter_trim,
   output logic [1:0] filter_outbuf_trim
);

   // ******************************************
   // State
   // ******************************************
   typedef struct packed {
      logic [dmc_pkg::WORD_W-1:0] shift;
      logic [dmc_pkg::CNT_W-1:0] nbits;
      logic clk_d;
      logic latch_d;
      logic osc_d;
      logic [dmc_pkg::WORD_W-1:0] cal_reg;
      logic [dmc_pkg::WORD_W-1:0] mix_reg;
      logic [dmc_pkg::WORD_W-1:0] bias_reg;
      logic [dmc_pkg::CAL_DIV_W-1:0] div_cnt;
      logic cal_tick;
   } dmc_regs_state_t;

   dmc_regs_state_t st;
   dmc_regs_state_t next_st;
   logic [3:0] pins_sync;
   logic s_clk;
   logic s_data;
   logic s_latch;
   logic s_osc;
   logic clk_rise;
   logic latch_rise;
   logic osc_rise;
   logic src_tick;
   logic word_ok;
   logic [dmc_pkg::REG_SEL_W-1:0] reg_sel;
   logic [dmc_pkg::BANK_W-1:0] bank_sel;

   function automatic logic [dmc_pkg::CAL_DIV_W-1:0] div_ratio(
      input logic [dmc_pkg::DIV_W-1:0] code
   );
      logic [dmc_pkg::CAL_DIV_W-1:0] r;
      r = dmc_pkg::DIV_R0;
      unique case (code)
         3'h0: r = dmc_pkg::DIV_R0;
         3'h1: r = dmc_pkg::DIV_R1;
         3'h2: r = dmc_pkg::DIV_R2;
         3'h3: r = dmc_pkg::DIV_R3;
         3'h4: r = dmc_pkg::DIV_R4;
         3'h5: r = dmc_pkg::DIV_R5;
         3'h6: r = dmc_pkg::DIV_R6;
         3'h7: r = dmc_pkg::DIV_R7;
      endcase
      return r;
   endfunction : div_ratio

   // ******************************************
   // Pin synchronisation
   // ******************************************
   dmc_sync #(
      .WIDTH(4)
   ) u_sync (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .d({osc_tick, ser_latch, ser_data, ser_clk}),
      .q(pins_sync)
   );

   assign s_clk = pins_sync[0];
   assign s_data = pins_sync[1];
   assign s_latch = pins_sync[2];
   assign s_osc = pins_sync[3];
   assign clk_rise = s_clk & ~st.clk_d;
   assign latch_rise = s_latch & ~st.latch_d;
   assign osc_rise = s_osc & ~st.osc_d;
   assign reg_sel = st.shift[dmc_pkg::REG_SEL_LSB +: dmc_pkg::REG_SEL_W];
   assign bank_sel = st.shift[dmc_pkg::BANK_LSB +: dmc_pkg::BANK_W];
   assign word_ok = latch_rise && (st.nbits == dmc_pkg::WORD_BITS);
   assign src_tick = st.cal_reg[dmc_pkg::CLK_SRC_BIT] ? osc_rise : clk_rise;

   // ******************************************
   // Next state
   // ******************************************
   always_comb begin
      next_st = st;
      if (clk_en) begin
         next_st.clk_d = s_clk;
         next_st.latch_d = s_latch;
         next_st.osc_d = s_osc;
         next_st.cal_tick = 1'b0;
         // Bit 0 arrives first, so it ends up at the bottom after 32 shifts
         if (clk_rise) begin
            next_st.shift = {s_data, st.shift[dmc_pkg::WORD_W-1:1]};
            if (st.nbits != dmc_pkg::CNT_OVER) begin
               next_st.nbits = st.nbits + 6'h01;
            end
         end
         // Calibration done clears the start bit; a host write wins
         if (cal_done && st.cal_reg[dmc_pkg::AUTOCAL_BIT]) begin
            next_st.cal_reg[dmc_pkg::AUTOCAL_BIT] = 1'b0;
         end
         // Short or long words are dropped so no register sees a
         // misaligned address
         if (latch_rise) begin
            next_st.nbits = '0;
         end
         if (word_ok && bank_sel == dmc_pkg::BANK_SETUP) begin
            unique case (reg_sel)
               dmc_pkg::REG_CAL: next_st.cal_reg = st.shift;
               dmc_pkg::REG_MIX: next_st.mix_reg = st.shift;
               dmc_pkg::REG_BIAS: next_st.bias_reg =
                  st.shift & dmc_pkg::BIAS_MASK;
               default: ;
            endcase
         end
         // Divider runs only while a calibration is requested
         if (!st.cal_reg[dmc_pkg::AUTOCAL_BIT]) begin
            next_st.div_cnt = '0;
         end else if (src_tick) begin
            if (st.div_cnt + dmc_pkg::DIV_ONE >= div_ratio(
                  st.cal_reg[dmc_pkg::DIV_LSB +: dmc_pkg::DIV_W])) begin
               next_st.div_cnt = '0;
               next_st.cal_tick = 1'b1;
            end else begin
               next_st.div_cnt = st.div_cnt + dmc_pkg::DIV_ONE;
            end
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         st <= '{shift: '0, nbits: '0, clk_d: 1'b0, latch_d: 1'b0,
                 osc_d: 1'b0, cal_reg: dmc_pkg::CAL_RESET,
                 mix_reg: dmc_pkg::MIX_RESET,
                 bias_reg: dmc_pkg::BIAS_RESET, div_cnt: '0,
                 cal_tick: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   // ******************************************
   // Field outputs, all slices of registers
   // ******************************************
   assign autocal_en = st.cal_reg[dmc_pkg::AUTOCAL_BIT];
   assign i_offset_dac_value = st.cal_reg[dmc_pkg::IDAC_LSB +: dmc_pkg::DAC_W];
   assign q_offset_dac_value =
      st.cal_reg[dmc_pkg::QDAC_LSB +: dmc_pkg::DAC_W];
   assign cal_ref_current_sel =
      st.cal_reg[dmc_pkg::IREF_LSB +: dmc_pkg::IREF_W];
   assign cal_mode_auto = st.cal_reg[dmc_pkg::CAL_MODE_BIT];
   assign cal_clk_div_sel = st.cal_reg[dmc_pkg::DIV_LSB +: dmc_pkg::DIV_W];
   assign cal_clk_src_osc = st.cal_reg[dmc_pkg::CLK_SRC_BIT];
   assign osc_trim =
      st.cal_reg[dmc_pkg::OSC_TRIM_LSB +: dmc_pkg::OSC_TRIM_W];
   assign cal_clk_tick = st.cal_tick;
   assign i_mixer_load_side_a =
      st.mix_reg[dmc_pkg::I_MIXER_LOAD_SIDE_A_LSB +: dmc_pkg::LOAD_W];
   assign i_mixer_load_side_b =
      st.mix_reg[dmc_pkg::I_MIXER_LOAD_SIDE_B_LSB +: dmc_pkg::LOAD_W];
   assign q_mixer_load_side_a =
      st.mix_reg[dmc_pkg::Q_MIXER_LOAD_SIDE_A_LSB +: dmc_pkg::LOAD_W];
   assign q_mixer_load_side_b =
      st.mix_reg[dmc_pkg::Q_MIXER_LOAD_SIDE_B_LSB +: dmc_pkg::LOAD_W];
   assign filter_bypass = st.mix_reg[dmc_pkg::BYPASS_BIT];
   assign filter_peak_ctrl = st.mix_reg[dmc_pkg::PEAK_LSB +: dmc_pkg::PEAK_W];
   assign mixer_transcond_trim =
      st.bias_reg[dmc_pkg::TRIM_LSB +: dmc_pkg::TRIM_W];
   assign mixer_switch_vcm_trim =
      st.bias_reg[dmc_pkg::TRIM_LSB + dmc_pkg::TRIM_W +: dmc_pkg::TRIM_W];
   assign lo_buffer_trim =
      st.bias_reg[dmc_pkg::TRIM_LSB + 2*dmc_pkg::TRIM_W +: dmc_pkg::TRIM_W];
   assign mixer_outbuf_trim =
      st.bias_reg[dmc_pkg::TRIM_LSB + 3*dmc_pkg::TRIM_W +: dmc_pkg::TRIM_W];
   assign filter_trim =
      st.bias_reg[dmc_pkg::TRIM_LSB + 4*dmc_pkg::TRIM_W +: dmc_pkg::TRIM_W];
   assign filter_outbuf_trim =
      st.bias_reg[dmc_pkg::TRIM_LSB + 5*dmc_pkg::TRIM_W +: dmc_pkg::TRIM_W];

endmodule : dmc_regs

// ===== hdl/dmc_pkg.sv
// Constants for the demodulator configuration register bank.
// Assumes 32-bit serial words, bit 0 shifted first, latched on a strobe.
package dmc_pkg;

   // ******************************************
   // Serial word layout
   // ******************************************
   localparam int WORD_W = 32;
   localparam int REG_SEL_LSB = 0;
   localparam int REG_SEL_W = 3;
   localparam int BANK_LSB = 3;
   localparam int BANK_W = 2;
   localparam int CNT_W = 6;
   localparam logic [CNT_W-1:0] WORD_BITS = 6'h20;
   localparam logic [CNT_W-1:0] CNT_OVER = 6'h21;
   localparam logic [BANK_W-1:0] BANK_SETUP = 2'h1;
   localparam logic [REG_SEL_W-1:0] REG_CAL = 3'h2;
   localparam logic [REG_SEL_W-1:0] REG_MIX = 3'h3;
   localparam logic [REG_SEL_W-1:0] REG_NOPROG = 3'h4;
   localparam logic [REG_SEL_W-1:0] REG_BIAS = 3'h5;

   // ******************************************
   // Calibration setup register fields
   // ******************************************
   localparam int AUTOCAL_BIT = 5;
   localparam int DAC_W = 8;
   localparam int IDAC_LSB = 6;
   localparam int QDAC_LSB = 14;
   localparam int IREF_LSB = 22;
   localparam int IREF_W = 2;
   localparam int CAL_MODE_BIT = 24;
   localparam int DIV_LSB = 25;
   localparam int DIV_W = 3;
   localparam int CLK_SRC_BIT = 28;
   localparam int OSC_TRIM_LSB = 29;
   localparam int OSC_TRIM_W = 3;
   localparam logic [WORD_W-1:0] CAL_RESET = 32'h71e0200a;

   // ******************************************
   // Mixer load and filter register fields
   // ******************************************
   localparam int LOAD_W = 6;
   localparam int I_MIXER_LOAD_SIDE_A_LSB = 5;
   localparam int I_MIXER_LOAD_SIDE_B_LSB = 11;
   localparam int Q_MIXER_LOAD_SIDE_A_LSB = 17;
   localparam int Q_MIXER_LOAD_SIDE_B_LSB = 23;
   localparam int BYPASS_BIT = 29;
   localparam int PEAK_LSB = 30;
   localparam int PEAK_W = 2;
   localparam logic [WORD_W-1:0] MIX_RESET = 32'h4000000b;

   // ******************************************
   // Bias trim register fields
   // ******************************************
   localparam int TRIM_LSB = 5;
   localparam int TRIM_W = 2;
   localparam int TRIM_N = 6;
   localparam logic [WORD_W-1:0] BIAS_RESET = 32'h0000aaad;
   localparam logic [WORD_W-1:0] BIAS_MASK = 32'h0001ffff;

   // ******************************************
   // Calibration clock divider ratios
   // ******************************************
   localparam int CAL_DIV_W = 15;
   localparam logic [CAL_DIV_W-1:0] DIV_R0 = 15'h0001;
   localparam logic [CAL_DIV_W-1:0] DIV_R1 = 15'h0008;
   localparam logic [CAL_DIV_W-1:0] DIV_R2 = 15'h0010;
   localparam logic [CAL_DIV_W-1:0] DIV_R3 = 15'h0080;
   localparam logic [CAL_DIV_W-1:0] DIV_R4 = 15'h0100;
   localparam logic [CAL_DIV_W-1:0] DIV_R5 = 15'h0400;
   localparam logic [CAL_DIV_W-1:0] DIV_R6 = 15'h0800;
   localparam logic [CAL_DIV_W-1:0] DIV_R7 = 15'h412c;
   localparam logic [CAL_DIV_W-1:0] DIV_ONE = 15'h0001;

endpackage : dmc_pkg

// ===== hdl/dmc_sync.sv
// Two-flop synchroniser for a group of asynchronous pin levels.
// Assumes the inputs are levels; edges are found after the second flop.
`timescale 1ns/1ps
module dmc_sync #(
   parameter int WIDTH = 4
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } dmc_sync_state_t;

   dmc_sync_state_t st;
   dmc_sync_state_t next_st;

   always_comb begin
      next_st = st;
      if (clk_en) begin
         next_st.meta = d;
         next_st.stable = st.meta;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign q = st.stable;

endmodule : dmc_sync

// ===== verification/dmc_regs_asserts.sv
// Port checker for the configuration register bank.
// Assumes it is bound to dmc_regs; pins change just after ref_clk edges.
`timescale 1ns/1ps
module dmc_regs_chk (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic ser_clk,
   input wire logic ser_latch,
   input wire logic osc_tick,
   input wire logic cal_done,
   input wire logic autocal_en,
   input wire logic [7:0] q_offset_dac_value,
   input wire logic [1:0] cal_ref_current_sel,
   input wire logic cal_mode_auto,
   input wire logic [2:0] cal_clk_div_sel,
   input wire logic cal_clk_src_osc,
   input wire logic cal_clk_tick,
   input wire logic filter_bypass,
   input wire logic [1:0] filter_peak_ctrl,
   input wire logic [1:0] lo_buffer_trim
);
   // ****
   // Cycles since each pin last rose, saturating
   // ****
   logic [2:0] pin_q;
   logic [3:0] s_lat, s_sck, s_osc;
   function automatic logic [3:0] nxt(input logic [3:0] c, input logic r);
      return r ? 4'h0 : (c == 4'hf ? c : c + 4'h1);
   endfunction : nxt
   always_ff @(posedge ref_clk) begin
      pin_q <= {ser_latch, ser_clk, osc_tick};
      s_lat <= !reset_n ? 4'hf : nxt(s_lat, ser_latch && !pin_q[2]);
      s_sck <= !reset_n ? 4'hf : nxt(s_sck, ser_clk && !pin_q[1]);
      s_osc <= !reset_n ? 4'hf : nxt(s_osc, osc_tick && !pin_q[0]);
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   a_reset_vals: assert property ($rose(reset_n) |->
      q_offset_dac_value == 8'h80 && cal_ref_current_sel == 2'h3 &&
      cal_mode_auto && cal_clk_src_osc && !autocal_en && !filter_bypass &&
      filter_peak_ctrl == 2'h1 && lo_buffer_trim == 2'h1 && !cal_clk_tick)
      else $error("reset values wrong");
   a_cfg_on_latch: assert property ($changed({q_offset_dac_value,
      filter_bypass, lo_buffer_trim, cal_clk_div_sel}) |->
      s_lat inside {[2:6]}) else $error("config changed without latch");
   a_autocal_set: assert property ($rose(autocal_en) |->
      s_lat inside {[2:6]}) else $error("autocal set without latch");
   a_autocal_clear: assert property (autocal_en && cal_done &&
      s_lat > 4'h8 |=> !autocal_en) else $error("autocal not cleared");
   a_tick_single: assert property (cal_clk_tick |=> !cal_clk_tick)
      else $error("tick longer than a cycle");
   a_tick_needs_auto: assert property (cal_clk_tick |->
      $past(autocal_en)) else $error("tick while autocal off");
   a_tick_source: assert property (cal_clk_tick |->
      (cal_clk_src_osc ? s_osc : s_sck) inside {[2:7]})
      else $error("tick not from selected source");
   a_tick_div_one: assert property (autocal_en && !cal_clk_src_osc &&
      cal_clk_div_sel == 3'h0 && $rose(ser_clk) |-> ##[2:6] cal_clk_tick)
      else $error("ratio one tick missing");
   a_freeze_hold: assert property (!clk_en |=> $stable({autocal_en,
      q_offset_dac_value, cal_clk_div_sel, filter_bypass, lo_buffer_trim,
      cal_clk_tick})) else $error("state moved while frozen");
   c_tick: cover property (cal_clk_tick);
   c_cal_done: cover property ($fell(autocal_en));
   c_bypass: cover property ($rose(filter_bypass));
endmodule : dmc_regs_chk
bind dmc_regs dmc_regs_chk i_dmc_regs_chk (.*);

// ===== verification/dmc_host.sv
// Host model that shifts words into the serial pins of the register bank.
// Assumes ref_clk is the bench clock; pins change 1 ns after its edges.
`timescale 1ns/1ps
module dmc_host (
   input wire logic ref_clk,
   output logic ser_clk,
   output logic ser_data,
   output logic ser_latch
);
   // ****
   // Word transfer, every level held 4 cycles so no edge is missed
   // ****
   initial begin
      ser_clk = 1'b0;
      ser_data = 1'b0;
      ser_latch = 1'b0;
   end
   task automatic wait_c(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : wait_c
   task automatic send(input logic [31:0] w, input int n);
      for (int i = 0; i < n; i++) begin
         ser_data = w[i];
         wait_c(4);
         ser_clk = 1'b1;
         wait_c(4);
         ser_clk = 1'b0;
      end
      wait_c(4);
      ser_latch = 1'b1;
      wait_c(4);
      ser_latch = 1'b0;
      // Released data must not keep looking valid
      ser_data = ~ser_data;
      wait_c(4);
   endtask : send
endmodule : dmc_host

// ===== verification/tb.sv
// Self-checking bench for the configuration register bank.
// Assumes dmc_host drives the serial pins and the checker binds itself.
`timescale 1ns/1ps
module tb;
   localparam logic [31:0] M5 = 32'hffffffe0;
   logic ref_clk, reset_n, clk_en, osc_tick, cal_done;
   logic ser_clk, ser_data, ser_latch, autocal_en, cal_mode_auto;
   logic cal_clk_src_osc, cal_clk_tick, filter_bypass;
   logic [7:0] i_offset_dac_value, q_offset_dac_value;
   logic [2:0] cal_clk_div_sel, osc_trim;
   logic [5:0] i_mixer_load_side_a, i_mixer_load_side_b;
   logic [5:0] q_mixer_load_side_a, q_mixer_load_side_b;
   logic [1:0] cal_ref_current_sel, filter_peak_ctrl, filter_trim;
   logic [1:0] mixer_transcond_trim, mixer_switch_vcm_trim;
   logic [1:0] lo_buffer_trim, mixer_outbuf_trim, filter_outbuf_trim;
   logic [26:0] cal_v, mix_v;
   logic [11:0] bias_v;
   logic [31:0] bad_w [4] = '{32'hfca, 32'hff2, 32'hfec, 32'hfee};
   int err_count = 0;
   int cmp_count = 0;
   int ticks = 0;
   assign cal_v = {osc_trim, cal_clk_src_osc, cal_clk_div_sel,
      cal_mode_auto, cal_ref_current_sel, q_offset_dac_value,
      i_offset_dac_value, autocal_en};
   assign mix_v = {filter_peak_ctrl, filter_bypass, q_mixer_load_side_b,
      q_mixer_load_side_a, i_mixer_load_side_b, i_mixer_load_side_a};
   assign bias_v = {filter_outbuf_trim, filter_trim, mixer_outbuf_trim,
      lo_buffer_trim, mixer_switch_vcm_trim, mixer_transcond_trim};
   dmc_regs i_dmc_regs (.*);
   dmc_host i_dmc_host (.*);
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) ticks <= ticks + int'(cal_clk_tick === 1'b1);
   // ****
   // Helpers
   // ****
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic rst8();
      reset_n = 1'b0;
      i_dmc_host.wait_c(8);
      reset_n = 1'b1;
      i_dmc_host.wait_c(1);
      chk({cal_v, 5'h0}, dmc_pkg::CAL_RESET & M5);
      chk({mix_v, 5'h0}, dmc_pkg::MIX_RESET & M5);
      chk({15'h0, bias_v, 5'h0}, dmc_pkg::BIAS_RESET & M5);
      $display("test reset finished");
   endtask : rst8
   task automatic osc(input int n);
      repeat (n) begin
         osc_tick = 1'b1;
         i_dmc_host.wait_c(4);
         osc_tick = 1'b0;
         i_dmc_host.wait_c(4);
      end
   endtask : osc
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop
   initial begin
      #100000;
      err_count++;
      report_and_stop();
   end
   // ****
   // Tests
   // ****
   initial begin
      reset_n = 1'b0;
      clk_en = 1'b1;
      osc_tick = 1'b0;
      cal_done = 1'b0;
      rst8();
      i_dmc_host.send(32'ha5c3c3ca, 32);
      chk({cal_v, 5'h0}, 32'ha5c3c3c0);
      i_dmc_host.send(32'h2000000b, 32);
      chk({mix_v, 5'h0}, 32'h20000000);
      i_dmc_host.send(32'hfffec9cd, 32);
      chk({15'h0, bias_v, 5'h0}, 32'h0000c9c0);
      $display("test writes finished");
      foreach (bad_w[k]) begin
         i_dmc_host.send(bad_w[k], k == 0 ? 31 : 32);
         chk({cal_v, 5'h0}, 32'ha5c3c3c0);
         chk({15'h0, bias_v, 5'h0}, 32'h0000c9c0);
      end
      $display("test refusals finished");
      i_dmc_host.send(32'h1200002a, 32);
      chk({cal_v, 5'h0}, 32'h12000020);
      osc(7);
      chk(ticks, 0);
      osc(1);
      chk(ticks, 1);
      cal_done = 1'b1;
      i_dmc_host.wait_c(1);
      cal_done = 1'b0;
      i_dmc_host.wait_c(2);
      chk({31'h0, autocal_en}, 32'h0);
      osc(8);
      chk(ticks, 1);
      $display("test oscillator finished");
      // A word shifted in while the clock enable is low must leave no trace
      clk_en = 1'b0;
      i_dmc_host.send(32'h0000c00a, 32);
      chk({cal_v, 5'h0}, 32'h12000000);
      clk_en = 1'b1;
      i_dmc_host.wait_c(8);
      chk({cal_v, 5'h0}, 32'h12000000);
      $display("test freeze finished");
      i_dmc_host.send(32'h0000002a, 32);
      chk(ticks, 1);
      i_dmc_host.send(32'h00000000, 32);
      chk(ticks, 33);
      $display("test serial clock finished");
      rst8();
      report_and_stop();
   end
endmodule : tb
